/* File: hw/fpt_reg_file.sv */
// Indexed timing register store for the flat panel timing generator.
// Assumes requests are synchronous to ref_clk, one access per cycle.
`timescale 1ns/1ns
`default_nettype none
module fpt_reg_file (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  // Register port
  input  wire fpt_pkg::fpt_reg_req_s   req,
  output var  logic [7:0]              rdData,
  // Contents to the timing logic
  output var  logic [15:0][7:0]        regs,
  output var  logic [15:0]             loaded
);
  import fpt_pkg::*;

  logic       hit;
  logic [3:0] slot;

  assign slot = req.index[3:0];
  assign hit  = (req.index[7:4] == IDX_BANK) && (req.index != IDX_UNUSED);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regs <= {16{REG_RESET}};
    end else if (req.wr && hit) begin
      regs[slot] <= req.wrData & WR_MASK[slot];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      loaded <= '0;
    end else if (req.wr && hit) begin
      loaded[slot] <= 1'b1;
    end
  end

  // Unmapped indices read zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 8'h00;
    end else if (req.rd) begin
      rdData <= hit ? regs[slot] : 8'h00;
    end
  end

endmodule
`default_nettype wire

/* File: hw/fpt_timing_gen.sv */
// Flat panel timing generator: character and scan line counters, blank and sync.
// Assumes ref_clk is the panel dot clock and software loads every timing register.
//
// Functional notes
// - Line length is horizontal total plus 5 character clocks.
// - Character counter advances once per 8 dot clocks in every mode.
// - Horizontal panel size holds horizontal resolution in characters minus one.
// - Horizontal blank starts when character count equals 9-bit blank start.
// - Horizontal blank ends when count low six bits match 6-bit blank end.
// - Line pulse starts at 9-bit sync start, bit eight from overflow.
// - Line pulse ends when count low five bits match sync end.
// - Horizontal overflow carries bit eight of total, size and blank start.
// - Timing values apply unchanged regardless of compensation or expansion.
// - Frame length is vertical total plus 2 lines, upper bits from overflow.
// - Vertical panel size holds vertical resolution in lines minus one.
// - Vertical blank starts at 11-bit vertical blank start line.
// - Vertical blank ends when line low eight bits match blank end.
// - Frame marker starts on line one past 11-bit sync start.
// - Frame marker ends when line low four bits match sync end.
`timescale 1ns/1ns
`default_nettype none
module fpt_timing_gen (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  // Register port
  input  wire fpt_pkg::fpt_reg_req_s   regReq,
  output var  logic [7:0]              regRdData,
  // Panel timing
  output var  fpt_pkg::fpt_panel_s     panelOut,
  output var  logic [10:0]             panelHSize,
  output var  logic [10:0]             panelVSize
);
  import fpt_pkg::*;

  logic [15:0][7:0] regs;
  logic [15:0]      loaded;
  logic             ready;
  logic [2:0]       dotCnt;
  logic [8:0]       hCnt;
  logic [10:0]      vCnt;
  logic [6:0]       hbRun;
  logic [5:0]       hsRun;
  logic             charTick;
  logic             lineEnd;
  logic             frameEnd;
  logic             hBlank;
  logic             linePulse;
  logic             vBlank;
  logic             frameMarkerPulse;

  // Decoded settings
  logic [8:0]  hTotal;
  logic [8:0]  hSize;
  logic [8:0]  hBlankStart;
  logic [5:0]  hBlankEnd;
  logic [8:0]  hSyncStart;
  logic [4:0]  hSyncEnd;
  logic        longHBlank;
  logic        longHSync;
  logic [10:0] vTotal;
  logic [10:0] vSize;
  logic [10:0] vBlankStart;
  logic [7:0]  vBlankEnd;
  logic [10:0] vSyncStart;
  logic [3:0]  vSyncEnd;
  logic [7:0]  hOv;
  logic [7:0]  hSe;
  logic [7:0]  vOvOne;
  logic [7:0]  vOvTwo;

  fpt_reg_file u_regs (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .req     (regReq),
    .rdData  (regRdData),
    .regs    (regs),
    .loaded  (loaded)
  );

  // Bytes that hold bits of several settings
  always_comb begin
    hOv    = regs[IDX_H_OVERFLOW[3:0]];
    hSe    = regs[IDX_H_SYNC_END[3:0]];
    vOvOne = regs[IDX_V_OVERFLOW_ONE[3:0]];
    vOvTwo = regs[IDX_V_OVERFLOW_TWO[3:0]];
  end

  // No compensation or expansion input exists; values are used as stored
  always_comb begin
    hTotal      = {hOv[HOV_HTOTAL_MSB], regs[IDX_H_TOTAL_LO[3:0]]};
    hSize       = {hOv[HOV_HSIZE_MSB], regs[IDX_H_SIZE_LO[3:0]]};
    hBlankStart = {hOv[HOV_HBLANK_START_MSB], regs[IDX_H_BLANK_START_LO[3:0]]};
    hBlankEnd   = {hSe[HSE_HBLANK_END_MSB], regs[IDX_H_BLANK_END[3:0]][4:0]};
    hSyncStart  = {hOv[HOV_HSYNC_START_MSB], regs[IDX_H_SYNC_START_LO[3:0]]};
    hSyncEnd    = hSe[HSE_FIELD_MSB:0];
    longHBlank  = hOv[HOV_LONG_HBLANK];
    longHSync   = hOv[HOV_LONG_HSYNC];
    vTotal      = {vOvOne[VOV_LO_LSB +: 3], regs[IDX_V_TOTAL_LO[3:0]]};
    vSize       = {vOvOne[VOV_HI_LSB +: 3], regs[IDX_V_SIZE_LO[3:0]]};
    vBlankStart = {vOvTwo[VOV_LO_LSB +: 3], regs[IDX_V_BLANK_START_LO[3:0]]};
    vBlankEnd   = regs[IDX_V_BLANK_END[3:0]];
    vSyncStart  = {vOvTwo[VOV_HI_LSB +: 3], regs[IDX_V_SYNC_START_LO[3:0]]};
    vSyncEnd    = regs[IDX_V_SYNC_END[3:0]][3:0];
  end

  // Registers reset to zero, not to usable timing, so the panel waits for a full load
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ready <= 1'b0;
    end else if ((loaded & ALL_LOADED) == ALL_LOADED) begin
      ready <= 1'b1;
    end
  end

  assign charTick = ready && (dotCnt == DOT_LAST);
  assign lineEnd  = charTick && (hCnt == hTotal + HTOTAL_ADJ);
  assign frameEnd = lineEnd && (vCnt == vTotal + VTOTAL_ADJ);
  // One flop per line, each in its own process, gathered into the struct
  assign panelOut = {hBlank, linePulse, vBlank, frameMarkerPulse};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dotCnt <= 3'h0;
    end else if (ready) begin
      dotCnt <= dotCnt + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hCnt <= 9'h000;
    end else if (lineEnd) begin
      hCnt <= 9'h000;
    end else if (charTick) begin
      hCnt <= hCnt + 9'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vCnt <= 11'h000;
    end else if (frameEnd) begin
      vCnt <= 11'h000;
    end else if (lineEnd) begin
      vCnt <= vCnt + 11'h001;
    end
  end

  // Panel size readback for the display path, as programmed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      panelHSize <= 11'h000;
      panelVSize <= 11'h000;
    end else begin
      panelHSize <= {2'b00, hSize};
      panelVSize <= vSize;
    end
  end

  logic hbStartHit;
  logic hbEndHit;
  logic hsStartHit;
  logic hsEndHit;
  assign hbStartHit = (hCnt == hBlankStart);
  // A 6-bit end value would match early in a long blank; the flag arms it late
  assign hbEndHit   = (hCnt[5:0] == hBlankEnd) &&
                      (!longHBlank || hbRun >= LONG_HBLANK_CHARS);
  assign hsStartHit = (hCnt == hSyncStart);
  assign hsEndHit   = (hCnt[4:0] == hSyncEnd) &&
                      (!longHSync || hsRun >= LONG_HSYNC_CHARS);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hBlank <= 1'b0;
    end else if (!ready) begin
      hBlank <= 1'b0;
    end else if (hbStartHit) begin
      hBlank <= 1'b1;
    end else if (hbEndHit) begin
      hBlank <= 1'b0;
    end
  end

  // Characters elapsed since blank start, saturating
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hbRun <= 7'h00;
    end else if (!panelOut.hBlank) begin
      hbRun <= 7'h00;
    end else if (charTick && hbRun != 7'h7f) begin
      hbRun <= hbRun + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      linePulse <= 1'b0;
    end else if (!ready) begin
      linePulse <= 1'b0;
    end else if (hsStartHit) begin
      linePulse <= 1'b1;
    end else if (hsEndHit) begin
      linePulse <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hsRun <= 6'h00;
    end else if (!panelOut.linePulse) begin
      hsRun <= 6'h00;
    end else if (charTick && hsRun != 6'h3f) begin
      hsRun <= hsRun + 6'h01;
    end
  end

  // Vertical state follows the line counter, which only moves at line end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vBlank <= 1'b0;
    end else if (!ready) begin
      vBlank <= 1'b0;
    end else if (vCnt == vBlankStart) begin
      vBlank <= 1'b1;
    end else if (vCnt[7:0] == vBlankEnd) begin
      vBlank <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frameMarkerPulse <= 1'b0;
    end else if (!ready) begin
      frameMarkerPulse <= 1'b0;
    end else if (vCnt == vSyncStart + VSYNC_ADJ) begin
      frameMarkerPulse <= 1'b1;
    end else if (vCnt[3:0] == vSyncEnd) begin
      frameMarkerPulse <= 1'b0;
    end
  end

  // Checks
  a_dot_wrap: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && dotCnt == DOT_LAST |=> (dotCnt == 3'h0 && $changed(hCnt)) || hCnt == 9'h000)
    else $error("character counter did not step after 8 dots");

  a_h_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    dotCnt != DOT_LAST |=> $stable(hCnt))
    else $error("character counter moved mid character");

  a_h_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    charTick && !lineEnd |=> hCnt == $past(hCnt) + 9'h001)
    else $error("character counter did not advance");

  a_h_wrap: assert property (@(posedge ref_clk) disable iff (!nrst)
    charTick && hCnt == hTotal + HTOTAL_ADJ && $stable(hTotal) |=> hCnt == 9'h000)
    else $error("character counter missed line total");

  a_v_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !lineEnd |=> $stable(vCnt))
    else $error("line counter moved mid line");

  a_v_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    lineEnd && !frameEnd |=> vCnt == $past(vCnt) + 11'h001)
    else $error("line counter did not advance");

  a_v_wrap: assert property (@(posedge ref_clk) disable iff (!nrst)
    lineEnd && vCnt == vTotal + VTOTAL_ADJ |=> vCnt == 11'h000)
    else $error("line counter missed frame total");

  a_hsize_out: assert property (@(posedge ref_clk) disable iff (!nrst)
    1'b1 |=> panelHSize == {2'b00, $past(hSize)})
    else $error("horizontal size output differs from setting");

  a_vsize_out: assert property (@(posedge ref_clk) disable iff (!nrst)
    1'b1 |=> panelVSize == $past(vSize))
    else $error("vertical size output differs from setting");

  a_hblank_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && hCnt == hBlankStart |=> panelOut.hBlank)
    else $error("horizontal blank did not start");

  a_hblank_end: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && !hbStartHit && hCnt[5:0] == hBlankEnd && !longHBlank |=> !panelOut.hBlank)
    else $error("horizontal blank did not end");

  a_long_hblank: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && !hbStartHit && longHBlank && hbRun < LONG_HBLANK_CHARS && panelOut.hBlank
    |=> panelOut.hBlank)
    else $error("long horizontal blank ended early");

  a_hb_run_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    !panelOut.hBlank |=> hbRun == 7'h00)
    else $error("blank length count not cleared");

  a_hb_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && !hbStartHit && !hbEndHit |=> $stable(panelOut.hBlank))
    else $error("horizontal blank changed without a match");

  a_lp_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && hCnt == hSyncStart |=> panelOut.linePulse)
    else $error("line pulse did not start");

  a_lp_end: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && !hsStartHit && hCnt[4:0] == hSyncEnd && !longHSync |=> !panelOut.linePulse)
    else $error("line pulse did not end");

  a_long_hsync: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && !hsStartHit && longHSync && hsRun < LONG_HSYNC_CHARS && panelOut.linePulse
    |=> panelOut.linePulse)
    else $error("long line pulse ended early");

  a_lp_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && !hsStartHit && !hsEndHit |=> $stable(panelOut.linePulse))
    else $error("line pulse changed without a match");

  a_vblank_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && vCnt == vBlankStart |=> panelOut.vBlank)
    else $error("vertical blank did not start");

  a_vblank_end: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && vCnt != vBlankStart && vCnt[7:0] == vBlankEnd |=> !panelOut.vBlank)
    else $error("vertical blank did not end");

  a_vb_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && vCnt != vBlankStart && vCnt[7:0] != vBlankEnd |=> $stable(panelOut.vBlank))
    else $error("vertical blank changed without a match");

  a_fm_start: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && vCnt == vSyncStart + VSYNC_ADJ |=> panelOut.frameMarkerPulse)
    else $error("frame marker did not start");

  a_fm_end: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && vCnt != vSyncStart + VSYNC_ADJ && vCnt[3:0] == vSyncEnd
    |=> !panelOut.frameMarkerPulse)
    else $error("frame marker did not end");

  a_fm_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready && vCnt != vSyncStart + VSYNC_ADJ && vCnt[3:0] != vSyncEnd
    |=> $stable(panelOut.frameMarkerPulse))
    else $error("frame marker changed without a match");

  a_dot_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    !ready |=> $stable(dotCnt))
    else $error("dot counter ran before load");

  a_ready_stays: assert property (@(posedge ref_clk) disable iff (!nrst)
    ready |=> ready)
    else $error("load state dropped without reset");

  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    !ready |=> panelOut == '0)
    else $error("panel output active before load");

endmodule
`default_nettype wire

/* File: inc/fpt_pkg.sv */
// Shared constants and carriers for the flat panel timing generator.
// Assumes the register port and the panel outputs share the panel dot clock.
package fpt_pkg;

  // Sequencer register indices
  localparam logic [7:0] IDX_H_TOTAL_LO       = 8'h60;
  localparam logic [7:0] IDX_H_SIZE_LO        = 8'h61;
  localparam logic [7:0] IDX_H_BLANK_START_LO = 8'h62;
  localparam logic [7:0] IDX_H_BLANK_END      = 8'h63;
  localparam logic [7:0] IDX_H_SYNC_START_LO  = 8'h64;
  localparam logic [7:0] IDX_H_SYNC_END       = 8'h65;
  localparam logic [7:0] IDX_H_OVERFLOW       = 8'h66;
  localparam logic [7:0] IDX_UNUSED           = 8'h67;
  localparam logic [7:0] IDX_V_TOTAL_LO       = 8'h68;
  localparam logic [7:0] IDX_V_SIZE_LO        = 8'h69;
  localparam logic [7:0] IDX_V_BLANK_START_LO = 8'h6a;
  localparam logic [7:0] IDX_V_BLANK_END      = 8'h6b;
  localparam logic [7:0] IDX_V_SYNC_START_LO  = 8'h6c;
  localparam logic [7:0] IDX_V_SYNC_END       = 8'h6d;
  localparam logic [7:0] IDX_V_OVERFLOW_ONE   = 8'h6e;
  localparam logic [7:0] IDX_V_OVERFLOW_TWO   = 8'h6f;
  localparam logic [3:0] IDX_BANK             = 4'h6;

  // Writable bits per slot; reserved bits store and read as zero
  localparam logic [15:0][7:0] WR_MASK = {
    8'h77, 8'h77, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h00, 8'h3f, 8'h9f, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff};
  // Every mapped slot must be written before the panel runs
  localparam logic [15:0]      ALL_LOADED = 16'hff7f;
  localparam logic [7:0]       REG_RESET  = 8'h00;

  // Horizontal overflow fields
  localparam int HOV_HTOTAL_MSB       = 0;
  localparam int HOV_HSIZE_MSB        = 1;
  localparam int HOV_HBLANK_START_MSB = 2;
  localparam int HOV_LONG_HBLANK      = 3;
  localparam int HOV_HSYNC_START_MSB  = 4;
  localparam int HOV_LONG_HSYNC       = 5;
  // Horizontal sync end fields
  localparam int HSE_HBLANK_END_MSB   = 7;
  localparam int HSE_FIELD_MSB        = 4;
  // Vertical overflow fields (low and high nibble groups)
  localparam int VOV_LO_LSB           = 0;
  localparam int VOV_HI_LSB           = 4;

  // Timing counts
  localparam logic [2:0] DOT_LAST      = 3'h7;  // 8 dots per character
  localparam logic [8:0] HTOTAL_ADJ    = 9'h004; // stored value is chars - 5
  localparam logic [10:0] VTOTAL_ADJ   = 11'h001; // stored value is lines - 2
  localparam logic [10:0] VSYNC_ADJ    = 11'h001; // stored value is line - 1
  localparam logic [6:0] LONG_HBLANK_CHARS = 7'h40;
  localparam logic [5:0] LONG_HSYNC_CHARS  = 6'h20;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wrData;
  } fpt_reg_req_s;

  typedef struct packed {
    logic hBlank;
    logic linePulse;
    logic vBlank;
    logic frameMarkerPulse;
  } fpt_panel_s;

endpackage

/* File: tb/fpt_panel_model.sv */
// Panel side model: watches the four timing lines and measures each one.
// Assumes panel outputs are registered on ref_clk and idle low.
`timescale 1ns/1ns
`default_nettype none
module fpt_panel_model
  import fpt_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // Timing lines from the controller
  input  wire fpt_pkg::fpt_panel_s panelIn,
  // Measured shape, index 3 hBlank down to 0 frame marker
  output var  logic [3:0][15:0] period,
  output var  logic [3:0][15:0] width,
  output var  logic [3:0][7:0]  rises
);
  logic [3:0]       sig;
  logic [3:0]       sigLast;
  logic [3:0][15:0] sinceRise;

  assign sig = panelIn;

  // First period after start is junk; readers wait for three rises
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sigLast   <= '0;
      sinceRise <= '0;
      period    <= '0;
      width     <= '0;
      rises     <= '0;
    end else begin
      sigLast <= sig;
      for (int i = 0; i < 4; i++) begin
        sinceRise[i] <= (sig[i] && !sigLast[i]) ? 16'h0001 : sinceRise[i] + 16'h0001;
        if (sig[i] && !sigLast[i]) begin
          period[i] <= sinceRise[i];
          rises[i]  <= rises[i] + 8'h01;
        end
        if (!sig[i] && sigLast[i]) begin
          width[i] <= sinceRise[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the flat panel timing generator.
// Assumes ref_clk is the dot clock; inputs change at falling edges.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module tb;
  import fpt_pkg::*;
  logic             ref_clk;
  logic             nrst;
  fpt_reg_req_s     regReq;
  logic [7:0]       regRdData;
  fpt_panel_s       panelOut;
  logic [10:0]      panelHSize;
  logic [10:0]      panelVSize;
  logic [3:0][15:0] period;
  logic [3:0][15:0] width;
  logic [3:0][7:0]  rises;
  logic [7:0]       rdVal;
  int               err_count;
  int               total_checks;

  // Line of 8 chars, frame of 6 lines; frame marker register loaded last
  localparam logic [7:0] LOAD_IDX [15] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66,
    8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6e, 8'h6f, 8'h6d};
  // Widths short, so both long flags stay clear
  localparam logic [7:0] LOAD_VAL [15] = '{8'h03, 8'h4f, 8'h05, 8'h07, 8'h06, 8'h01, 8'h02,
    8'h04, 8'hdf, 8'h03, 8'h05, 8'h00, 8'h10, 8'h00, 8'h03};
  localparam logic [7:0] MASK_IDX [8] = '{8'h63, 8'h65, 8'h66, 8'h67, 8'h6d, 8'h6e, 8'h6f, 8'h60};
  localparam logic [7:0] MASK_EXP [8] = '{8'h1f, 8'h9f, 8'h3f, 8'h00, 8'h0f, 8'h77, 8'h77, 8'hff};

  fpt_timing_gen uut (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .regReq     (regReq),
    .regRdData  (regRdData),
    .panelOut   (panelOut),
    .panelHSize (panelHSize),
    .panelVSize (panelVSize)
  );

  fpt_panel_model panel (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .panelIn (panelOut),
    .period  (period),
    .width   (width),
    .rises   (rises)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // One access, one idle cycle, then read data is settled
  task automatic reg_access(input logic wr, input logic rdEn, input logic [7:0] idx,
                            input logic [7:0] data);
    @(negedge ref_clk);
    regReq = '{wr: wr, rd: rdEn, index: idx, wrData: data};
    @(negedge ref_clk);
    regReq = '0;
    @(negedge ref_clk);
    rdVal = regRdData;
  endtask

  task automatic test_gated();
    for (int i = 0; i < 14; i++) begin
      reg_access(1'b1, 1'b0, LOAD_IDX[i], LOAD_VAL[i]);
    end
    repeat (200) @(negedge ref_clk);
    `CHK("panel idle", 4'h0, panelOut)
    `CHK("rises idle", 32'h0, rises)
    $display("test gated done");
  endtask

  task automatic test_timing();
    reg_access(1'b1, 1'b0, LOAD_IDX[14], LOAD_VAL[14]);
    for (int n = 0; n < 3000 && rises[0] < 8'h03; n++) begin
      @(negedge ref_clk);
    end
    `CHK("line period", 16'd64, period[2])
    `CHK("hblank period", 16'd64, period[3])
    `CHK("hblank width", 16'd16, width[3])
    `CHK("line pulse width", 16'd24, width[2])
    `CHK("frame period", 16'd384, period[0])
    `CHK("frame marker width", 16'd128, width[0])
    `CHK("vblank period", 16'd384, period[1])
    `CHK("vblank width", 16'd128, width[1])
    `CHK("h size", 11'h14f, panelHSize)
    `CHK("v size", 11'h1df, panelVSize)
    $display("test timing done");
  endtask

  task automatic test_sizes();
    reg_access(1'b1, 1'b0, 8'h66, 8'h10);
    reg_access(1'b0, 1'b1, 8'h66, 8'h00);
    `CHK("h overflow", 8'h10, rdVal)
    repeat (4) @(negedge ref_clk);
    `CHK("h size msb", 11'h04f, panelHSize)
    reg_access(1'b1, 1'b0, 8'h66, 8'h02);
    repeat (4) @(negedge ref_clk);
    `CHK("h size restored", 11'h14f, panelHSize)
    $display("test sizes done");
  endtask

  task automatic test_regs();
    for (int i = 0; i < 8; i++) begin
      reg_access(1'b1, 1'b0, MASK_IDX[i], 8'hff);
      reg_access(1'b0, 1'b1, MASK_IDX[i], 8'h00);
      `CHK("register readback", MASK_EXP[i], rdVal)
    end
    $display("test regs done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Tests need about 1200 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    final_report();
  end

  initial begin
    err_count = 0;
    total_checks = 0;
    nrst = 1'b0;
    regReq = '0;
    rdVal = '0;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    test_gated();
    test_timing();
    test_sizes();
    test_regs();
    final_report();
  end
endmodule
`default_nettype wire
